// ---- logic/spc_pkg.sv ----
// package of constants for the stacked pot cascade shift port
// assumes a 200 MHz system clock on both ends
package spc_pkg;

  // ****************************************
  // shift register layout
  // ****************************************
  localparam int unsigned SR_BITS     = 17;
  localparam int unsigned WIPER_BITS  = 8;
  localparam int unsigned STACK_POS   = 0;
  localparam int unsigned W1_MSB_POS  = 1;
  localparam int unsigned W0_MSB_POS  = 9;
  localparam int unsigned POS_BITS    = 9;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [16:0] SR_RST      = 17'h00000;
  localparam logic [7:0]  WIPER_RST   = 8'h00;
  localparam logic        STACK_RST   = 1'b0;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_NS      = 5;
  localparam int unsigned T_CH_NS     = 50;
  localparam int unsigned T_CC_NS     = 50;
  localparam int unsigned T_HLT_NS    = 50;
  localparam int unsigned T_RLT_NS    = 125;
  localparam int unsigned T_CLK_MIN_NS = 100;

  localparam int unsigned CNT_CH      = (T_CH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_HALF    = ((T_CLK_MIN_NS / 2) + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_CC      = (T_CC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_HLT     = (T_HLT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_RLT     = (T_RLT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W       = 8;

  // ****************************************
  // host states
  // ****************************************
  typedef enum logic [5:0] {
    SPC_IDLE = 6'h01,
    SPC_LEAD = 6'h02,
    SPC_LOW  = 6'h04,
    SPC_HIGH = 6'h08,
    SPC_TAIL = 6'h10,
    SPC_GAP  = 6'h20
  } spc_state_t;

endpackage

// ---- logic/spc_if.sv ----
// interface joining the host end and the device end of the three-wire port
// assumes the bench drives fb_dq with the looped cascade level, or a pull level
`timescale 1ns/100ps
interface spc_if;
  logic xfer_en;
  logic sclk;
  logic host_dq;
  logic host_dq_oe_n;
  logic fb_dq;
  logic cout;
  logic dq;

  // data line level: host drive wins, else the feedback path
  assign dq = host_dq_oe_n ? fb_dq : host_dq;

  modport dev
  (
    input  xfer_en,
    input  sclk,
    input  dq,
    output cout
  );

  modport host
  (
    output xfer_en,
    output sclk,
    output host_dq,
    output host_dq_oe_n,
    input  dq
  );
endinterface

// ---- logic/spc_host.sv ----
// host end: drives transfer enable, divided serial clock and data
// assumes the chain length in devices is given by the DEVICES parameter
`timescale 1ns/100ps
module spc_host
#(
  parameter int unsigned DEVICES = 1,
  parameter int unsigned NBITS   = spc_pkg::SR_BITS * DEVICES
)
(
  input  wire logic             clk,
  input  wire logic             rstn,
  spc_if.host                   link,
  input  wire logic             start,
  input  wire logic             read_back,
  input  wire logic [NBITS-1:0] tx_data,
  output logic      [NBITS-1:0] rx_data,
  output logic                  busy,
  output logic                  done
);

  localparam int unsigned BW = $clog2(NBITS + 1);

  // ****************************************
  // state
  // ****************************************
  spc_pkg::spc_state_t       st_r;
  spc_pkg::spc_state_t       st_nxt;
  logic [spc_pkg::CNT_W-1:0] cnt_r;
  logic [BW-1:0]             bit_r;
  logic [NBITS-1:0]          tx_r;
  logic [NBITS-1:0]          rx_r;
  logic                      rd_r;
  logic                      en_r;
  logic                      sclk_r;
  logic                      dq_r;
  logic                      oe_n_r;
  logic                      busy_r;
  logic                      done_r;
  logic                      dq_s1;
  logic                      dq_s2;

  wire cnt_end  = (cnt_r == '0);
  wire last_bit = (bit_r == BW'(NBITS - 1));

  function automatic logic [spc_pkg::CNT_W-1:0] ld(input int unsigned n);
    ld = spc_pkg::CNT_W'(n - 1);
  endfunction

  // ****************************************
  // sequencing
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      spc_pkg::SPC_IDLE: if (start) st_nxt = spc_pkg::SPC_LEAD;
      spc_pkg::SPC_LEAD: if (cnt_end) st_nxt = spc_pkg::SPC_HIGH;
      spc_pkg::SPC_HIGH: if (cnt_end) st_nxt = last_bit ? spc_pkg::SPC_TAIL : spc_pkg::SPC_LOW;
      spc_pkg::SPC_LOW:  if (cnt_end) st_nxt = spc_pkg::SPC_HIGH;
      spc_pkg::SPC_TAIL: if (cnt_end) st_nxt = spc_pkg::SPC_GAP;
      spc_pkg::SPC_GAP:  if (cnt_end) st_nxt = spc_pkg::SPC_IDLE;
      default:           st_nxt = spc_pkg::SPC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dq_s1 <= 1'b0;
      dq_s2 <= 1'b0;
    end
    else
    begin
      dq_s1 <= link.dq;
      dq_s2 <= dq_s1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r   <= spc_pkg::SPC_IDLE;
      cnt_r  <= '0;
      bit_r  <= '0;
      tx_r   <= '0;
      rx_r   <= '0;
      rd_r   <= 1'b0;
      en_r   <= 1'b0;
      sclk_r <= 1'b0;
      dq_r   <= 1'b0;
      oe_n_r <= 1'b1;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      st_r   <= st_nxt;
      done_r <= 1'b0;
      cnt_r  <= cnt_end ? '0 : cnt_r - 1'b1;
      case (st_r)
        spc_pkg::SPC_IDLE:
          if (start)
          begin
            tx_r   <= tx_data;
            rd_r   <= read_back;
            en_r   <= 1'b1;
            busy_r <= 1'b1;
            bit_r  <= '0;
            dq_r   <= tx_data[0];
            oe_n_r <= read_back;
            cnt_r  <= ld(spc_pkg::CNT_CC);
          end
        spc_pkg::SPC_LEAD:
          if (cnt_end)
          begin
            sclk_r <= 1'b1;
            rx_r   <= {dq_s2, rx_r[NBITS-1:1]};
            cnt_r  <= ld(spc_pkg::CNT_HALF);
          end
        spc_pkg::SPC_HIGH:
          if (cnt_end)
          begin
            sclk_r <= 1'b0;
            if (last_bit)
              cnt_r <= ld(spc_pkg::CNT_HLT);
            else
            begin
              bit_r <= bit_r + 1'b1;
              tx_r  <= {1'b0, tx_r[NBITS-1:1]};
              dq_r  <= tx_r[1];
              cnt_r <= ld(spc_pkg::CNT_HALF);
            end
          end
        spc_pkg::SPC_LOW:
          if (cnt_end)
          begin
            sclk_r <= 1'b1;
            rx_r   <= {dq_s2, rx_r[NBITS-1:1]};
            cnt_r  <= ld(spc_pkg::CNT_HALF);
          end
        spc_pkg::SPC_TAIL:
          if (cnt_end)
          begin
            en_r   <= 1'b0;
            oe_n_r <= 1'b1;
            cnt_r  <= ld(spc_pkg::CNT_RLT);
          end
        spc_pkg::SPC_GAP:
          if (cnt_end)
          begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
          end
        default: ;
      endcase
    end
  end

  assign link.xfer_en      = en_r;
  assign link.sclk         = sclk_r;
  assign link.host_dq      = dq_r;
  assign link.host_dq_oe_n = oe_n_r;
  assign rx_data           = rx_r;
  assign busy              = busy_r;
  assign done              = done_r;

endmodule // spc_host

// ---- logic/spc_dev.sv ----
// device end: 17-bit shift register, cascade output, wiper latches
// assumes transfer enable, serial clock and data arrive asynchronous to clk
//
// Functional notes
// - stack-select bit chooses stacked wiper source
// - select 0 gives pot zero, 1 pot one
// - stacked position spans 512 values
// - each shifted-in bit shifts one bit out
// - stack-select bit leaves first each transfer
// - idle cascade output shows stored stack-select
// - cascade output can feed next device data
// - controller clocks 17 bits per device
// - looped chain lets controller read or recirculate
// - controller releases data line during readback
// - enable rise presents bit 17 immediately
// - clock rise loads bit, presents bit 16
// - full rotation restores original register contents
// - enable fall loads wipers and stack-select
// - fixed bit layout of the shift register
// - active only while enable high, sample rise
// - wipers change only after enable falls
// - order is stack, pot one, pot zero
`timescale 1ns/100ps
module spc_dev
(
  input  wire logic                          clk,
  input  wire logic                          rstn,
  spc_if.dev                                 link,
  output logic [spc_pkg::WIPER_BITS-1:0]     wiper_of_pot_zero,
  output logic [spc_pkg::WIPER_BITS-1:0]     wiper_of_pot_one,
  output logic                               stack_select_flag,
  output logic [spc_pkg::WIPER_BITS-1:0]     stacked_wiper,
  output logic [spc_pkg::POS_BITS-1:0]       stacked_pos,
  output logic [spc_pkg::SR_BITS-1:0]        shift_image,
  output logic                               port_active
);

  // ****************************************
  // declarations
  // ****************************************
  logic                                en_s1;
  logic                                en_s2;
  logic                                en_d;
  logic                                ck_s1;
  logic                                ck_s2;
  logic                                ck_d;
  logic                                dq_s1;
  logic                                dq_s2;
  logic [spc_pkg::SR_BITS-1:0]         sr_r;
  logic [spc_pkg::SR_BITS-1:0]         sr_nxt;
  logic [spc_pkg::WIPER_BITS-1:0]      w0_r;
  logic [spc_pkg::WIPER_BITS-1:0]      w1_r;
  logic                                sel_r;
  logic [spc_pkg::WIPER_BITS-1:0]      sw_r;
  logic [spc_pkg::WIPER_BITS-1:0]      sw_nxt;
  logic [spc_pkg::POS_BITS-1:0]        pos_r;
  logic [spc_pkg::POS_BITS-1:0]        pos_nxt;
  logic                                act_r;

  // ****************************************
  // field extraction
  // ****************************************
  // msb sits at the lowest position of each field
  function automatic logic [spc_pkg::WIPER_BITS-1:0] field_at
  (
    input logic [spc_pkg::SR_BITS-1:0] sr,
    input int unsigned                 msb_pos
  );
    logic [spc_pkg::WIPER_BITS-1:0] v;
    v = '0;
    for (int i = 0; i < spc_pkg::WIPER_BITS; i++)
      v[spc_pkg::WIPER_BITS-1-i] = sr[msb_pos+i];
    return v;
  endfunction

  // ****************************************
  // input synchronisers
  // ****************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
      en_d  <= 1'b0;
    end
    else
    begin
      en_s1 <= link.xfer_en;
      en_s2 <= en_s1;
      en_d  <= en_s2;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_d  <= 1'b0;
    end
    else
    begin
      ck_s1 <= link.sclk;
      ck_s2 <= ck_s1;
      ck_d  <= ck_s2;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dq_s1 <= 1'b0;
      dq_s2 <= 1'b0;
    end
    else
    begin
      dq_s1 <= link.dq;
      dq_s2 <= dq_s1;
    end
  end

  // ****************************************
  // edge decode
  // ****************************************
  // true when the first level is high and the second is low
  function automatic logic hi_not_lo
  (
    input logic hi_lvl,
    input logic lo_lvl
  );
    return hi_lvl & ~lo_lvl;
  endfunction

  // clock rise counts only while the port is enabled
  wire shift_edge = en_s2 & hi_not_lo(ck_s2, ck_d);
  // enable fall arms the wiper load
  wire end_edge   = hi_not_lo(en_d, en_s2);

  // ****************************************
  // shift register
  // ****************************************
  // new bit enters the top, the bit at position 0 leaves on the cascade pin
  assign sr_nxt = {dq_s2, sr_r[spc_pkg::SR_BITS-1:1]};

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sr_r <= spc_pkg::SR_RST;
    else if (shift_edge)
      sr_r <= sr_nxt;
  end

  // ****************************************
  // wiper latches
  // ****************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      w0_r  <= spc_pkg::WIPER_RST;
      w1_r  <= spc_pkg::WIPER_RST;
      sel_r <= spc_pkg::STACK_RST;
    end
    else if (end_edge)
    begin
      w0_r  <= field_at(sr_r, spc_pkg::W0_MSB_POS);
      w1_r  <= field_at(sr_r, spc_pkg::W1_MSB_POS);
      sel_r <= sr_r[spc_pkg::STACK_POS];
    end
  end

  // ****************************************
  // stacked output
  // ****************************************
  assign sw_nxt  = sel_r ? w1_r : w0_r;
  assign pos_nxt = {sel_r, sw_nxt};

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sw_r  <= spc_pkg::WIPER_RST;
      pos_r <= '0;
      act_r <= 1'b0;
    end
    else
    begin
      sw_r  <= sw_nxt;
      pos_r <= pos_nxt;
      act_r <= en_s2;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // position 0 leaves first: stored stack bit while idle and at enable rise
  assign link.cout         = sr_r[spc_pkg::STACK_POS];
  assign wiper_of_pot_zero = w0_r;
  assign wiper_of_pot_one  = w1_r;
  assign stack_select_flag = sel_r;
  assign stacked_wiper     = sw_r;
  assign stacked_pos       = pos_r;
  assign shift_image       = sr_r;
  assign port_active       = act_r;

endmodule // spc_dev

// ---- tb/spc_link_monitor.sv ----
// checker on the three-wire link between the host end and the device end
// assumes one host and one device joined by spc_if, both on clk
`timescale 1ns/100ps
module spc_link_monitor
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic xfer_en,
  input wire logic sclk,
  input wire logic host_dq,
  input wire logic host_dq_oe_n,
  input wire logic cout
);
  logic       sclk_q_r;
  logic [4:0] rises_r;
  logic [3:0] since_r;
  wire        sclk_rise = sclk && !sclk_q_r;

  // ****************
  // helper counters
  // ****************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sclk_q_r <= 1'b0;
    else
      sclk_q_r <= sclk;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rises_r <= 5'h00;
    else if (!xfer_en)
      rises_r <= 5'h00;
    else if (sclk_rise)
      rises_r <= rises_r + 5'h01;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      since_r <= 4'hF;
    else if (sclk_rise)
      since_r <= 4'h0;
    else if (since_r != 4'hF)
      since_r <= since_r + 4'h1;
  end

  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_cout_idle_hold: assert property (!xfer_en && !$past(xfer_en) |-> $stable(cout))
    else $error("cascade output moved while idle");
  a_cout_enable_rise: assert property ($rose(xfer_en) |-> $stable(cout) [*8])
    else $error("cascade output moved at enable rise");
  a_cout_after_rise: assert property ($changed(cout) |-> since_r inside {[1:6]})
    else $error("cascade output moved without a clock rise");
  a_bit_count: assert property ($fell(xfer_en) |-> rises_r == 5'h11)
    else $error("transfer did not carry 17 clocks");
  a_sclk_gated: assert property (sclk |-> xfer_en)
    else $error("serial clock high outside enable");
  a_lead_time: assert property ($rose(xfer_en) |-> !sclk [*8])
    else $error("clock too soon after enable");
  a_high_width: assert property ($rose(sclk) |-> sclk [*8])
    else $error("serial clock high too short");
  a_low_width: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("serial clock low too short");
  a_tail_time: assert property ($fell(xfer_en) |-> !$past(sclk, 8))
    else $error("enable dropped too soon after clock");
  a_idle_release: assert property (!xfer_en |-> host_dq_oe_n)
    else $error("host drives data while idle");
  a_oe_steady: assert property (xfer_en && $past(xfer_en) |-> $stable(host_dq_oe_n))
    else $error("data drive changed mid transfer");
  a_data_hold: assert property (sclk && $past(sclk) && !host_dq_oe_n |-> $stable(host_dq))
    else $error("host data moved while clock high");
  a_enable_gap: assert property ($rose(xfer_en) |-> !$past(xfer_en, 24))
    else $error("enable low time too short");

  c_write: cover property ($rose(xfer_en) && !host_dq_oe_n);
  c_read: cover property ($rose(xfer_en) && host_dq_oe_n);
  c_shift: cover property ($changed(cout) && xfer_en);
endmodule // spc_link_monitor

// ---- tb/test_stacked_pot_cascade_shift_port.sv ----
// self-checking bench for the host end and device end of the three-wire port
// assumes the looped cascade output feeds back as the data line level
`timescale 1ns/100ps
module test_stacked_pot_cascade_shift_port;
  logic        clk       = 1'b0;
  logic        rstn      = 1'b0;
  logic        start     = 1'b0;
  logic        read_back = 1'b0;
  logic [16:0] tx_data   = 17'h00000;
  logic [16:0] rx_data, img, img2, cur;
  logic        busy, done, sel, act;
  logic [7:0]  w0, w1, sw, w0b;
  logic [8:0]  pos;
  logic [16:0] vec [4] = '{17'h00001, 17'h1FFFE, 17'h15555, 17'h0A5C3};
  int          n_errors   = 0;
  int          num_checks = 0;

  spc_if link ();
  spc_if link2 ();
  assign link.fb_dq = link.cout;
  always #2.5 clk = ~clk;

  spc_host spc_host_inst (.clk(clk), .rstn(rstn), .link(link.host), .start(start),
    .read_back(read_back), .tx_data(tx_data), .rx_data(rx_data), .busy(busy), .done(done));
  spc_dev spc_dev_inst (.clk(clk), .rstn(rstn), .link(link.dev), .wiper_of_pot_zero(w0),
    .wiper_of_pot_one(w1), .stack_select_flag(sel), .stacked_wiper(sw), .stacked_pos(pos),
    .shift_image(img), .port_active(act));
  spc_dev spc_dev2_inst (.clk(clk), .rstn(rstn), .link(link2.dev), .wiper_of_pot_zero(w0b),
    .wiper_of_pot_one(), .stack_select_flag(), .stacked_wiper(), .stacked_pos(),
    .shift_image(img2), .port_active());
  spc_link_monitor spc_link_monitor_inst (.clk(clk), .rstn(rstn), .xfer_en(link.xfer_en),
    .sclk(link.sclk), .host_dq(link.host_dq), .host_dq_oe_n(link.host_dq_oe_n),
    .cout(link.cout));

  // ****************
  // helpers
  // ****************
  function automatic logic [7:0] rev8(input logic [7:0] x);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = x[7 - i];
    return r;
  endfunction

  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check_dev(input logic [16:0] s);
    logic [7:0] e0, e1;
    e1 = rev8(s[8:1]);
    e0 = rev8(s[16:9]);
    check(img, s);
    check(17'(w1), 17'(e1));
    check(17'(w0), 17'(e0));
    check(17'(sel), 17'(s[0]));
    check(17'(sw), 17'(s[0] ? e1 : e0));
    check(17'(pos), 17'({s[0], s[0] ? e1 : e0}));
    check(17'(link.cout), 17'(s[0]));
  endtask

  task automatic xfer(input logic rb, input logic [16:0] d);
    int k;
    @(negedge clk);
    start = 1'b1;
    read_back = rb;
    tx_data = d;
    @(negedge clk);
    start = 1'b0;
    repeat (200) @(negedge clk);
    check({sel, rev8(w0), rev8(w1)}, {cur[0], cur[16:9], cur[8:1]});
    check(17'({busy, act}), 17'h00003);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 1000)
    begin
      @(negedge clk);
      k++;
    end
    check(17'(k < 1000), 17'h00001);
    check(17'({busy, act}), 17'h00000);
    repeat (6) @(negedge clk);
  endtask

  task automatic bang(input logic [8:0] v);
    link2.xfer_en = 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      link2.host_dq = v[i];
      repeat (12) @(negedge clk);
      link2.sclk = 1'b1;
      repeat (12) @(negedge clk);
      link2.sclk = 1'b0;
    end
    repeat (12) @(negedge clk);
    link2.xfer_en = 1'b0;
    repeat (12) @(negedge clk);
  endtask

  // ****************
  // sequence
  // ****************
  initial
  begin
    link2.xfer_en = 1'b0;
    link2.sclk = 1'b0;
    link2.host_dq = 1'b0;
    link2.host_dq_oe_n = 1'b0;
    link2.fb_dq = 1'b0;
    cur = 17'h00000;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    check_dev(cur);
    foreach (vec[i])
    begin
      xfer(1'b0, vec[i]);
      cur = vec[i];
      check_dev(cur);
    end
    xfer(1'b1, 17'h1FFFF);
    check(rx_data, cur);
    check_dev(cur);
    bang(9'h1A5);
    check(img2, {9'h1A5, 8'h00});
    check(17'(w0b), 17'(rev8(8'hD2)));
    results();
  end

  initial
  begin
    #40000;
    n_errors++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    results();
  end
endmodule // test_stacked_pot_cascade_shift_port
